// ### logic/cfas_pkg.sv
// Contract
// RULE1: 8-bit data path, separate 14-bit instruction path
// RULE2: addresses 70h-7Fh reach one cell in every bank
// RULE3: direct access uses address inside instruction word
// RULE4: indirect location accesses address held in pointer
// RULE5: next word fetched while current instruction executes
// RULE6: instruction cycle is four oscillator periods
// RULE7: phases decode, read, execute, write per cycle
// RULE8: one word per instruction, one cycle each; call, goto, return, retlw and retfie take two, the prefetch flushed
// RULE9: opcode field variable length, from three bits; call and goto decode on three bits
// RULE10: interrupt pushes counter, then jumps to 04h
// RULE11: call/jump 11-bit target, page from latch bits 5:4
// RULE12: 7 direct bits plus two bank select bits
// RULE13: call pushes program counter onto hardware stack
// RULE14: counter advances one word per fetched instruction
`default_nettype none
package cfas_pkg;
    localparam int DATA_W = 8;
    localparam int INSTR_W = 14;
    localparam int PC_W = 13;
    localparam int DADDR_W = 9;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 3;
    localparam int EV_W = 3;
    localparam int APB_AW = 12;
    localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
    localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
    localparam logic [6:0] COMMON_LO = 7'h70;
    localparam logic [6:0] INDIRECT_LOC = 7'h00;
    localparam logic [3:0] STACK_FULL = 4'h8;
    // apb register byte addresses
    localparam logic [APB_AW-1:0] ADDR_CTRL = 12'h000;
    localparam logic [APB_AW-1:0] ADDR_PC_HIGH_LATCH = 12'h004;
    localparam logic [APB_AW-1:0] ADDR_POINTER = 12'h008;
    localparam logic [APB_AW-1:0] ADDR_BANK = 12'h00c;
    localparam logic [APB_AW-1:0] ADDR_PC = 12'h010;
    localparam logic [APB_AW-1:0] ADDR_STATUS = 12'h014;
    localparam logic [APB_AW-1:0] ADDR_MASK = 12'h018;
    localparam logic [APB_AW-1:0] ADDR_WREG = 12'h01c;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_GIE = 1;
    localparam int EV_VECTOR = 0;
    localparam int EV_OVERFLOW = 1;
    localparam int EV_UNDERFLOW = 2;
    // instruction encoding
    localparam logic [1:0] CLS_BYTE = 2'b00;
    localparam logic [2:0] OP_CALL = 3'b100;
    localparam logic [2:0] OP_GOTO = 3'b101;
    localparam logic [3:0] OP_MOVWF = 4'h0;
    localparam logic [3:0] OP_CLRF = 4'h1;
    localparam logic [3:0] OP_DECF = 4'h3;
    localparam logic [3:0] OP_ADDWF = 4'h7;
    localparam logic [3:0] OP_MOVF = 4'h8;
    localparam logic [3:0] OP_INCF = 4'ha;
    localparam logic [3:0] LIT_MOVLW = 4'hc;
    localparam logic [3:0] LIT_RETLW = 4'hd;
    localparam logic [INSTR_W-1:0] INSN_NOP = 14'h0000;
    localparam logic [INSTR_W-1:0] INSN_RETURN = 14'h0008;
    localparam logic [INSTR_W-1:0] INSN_RETFIE = 14'h0009;
    typedef enum logic [3:0] {
        q_decode = 4'b0001,
        q_read = 4'b0010,
        q_execute = 4'b0100,
        q_write = 4'b1000
    } cfas_phase_t;
    typedef struct packed {
        logic [DADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic re;
        logic we;
    } cfas_dmem_req_t;
endpackage
`default_nettype wire

// ### logic/cfas_core.sv
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cfas_core
    import cfas_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output var logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [PC_W-1:0] prog_addr,
    input wire logic [INSTR_W-1:0] prog_data,
    output var cfas_dmem_req_t dmem_req,
    input wire logic [DATA_W-1:0] dmem_rdata,
    input wire logic ext_irq,
    output logic irq
);

    cfas_phase_t phase;
    cfas_phase_t next_phase;
    logic run;
    logic gie;
    logic [7:0] pc_high_latch;
    logic [7:0] pointer;
    logic [1:0] bank;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] next_pc;
    logic [INSTR_W-1:0] ir;
    logic [INSTR_W-1:0] next_ir;
    logic [DATA_W-1:0] wreg;
    logic [DATA_W-1:0] operand;
    logic [DATA_W-1:0] result;
    logic [PC_W-1:0] stack [STACK_DEPTH];
    logic [SP_W-1:0] sp;
    logic [3:0] depth;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic irq_s1;
    logic irq_s2;

    // ---- decode: two-bit class, then three, then four bits
    wire logic [1:0] cls = ir[13:12];
    wire logic [3:0] byte_op = ir[11:8];
    wire logic dest_f = ir[7];
    wire logic [6:0] fld = ir[6:0];
    wire logic is_call = ir[13:11] == OP_CALL; // RULE9
    wire logic is_goto = ir[13:11] == OP_GOTO; // RULE9
    wire logic is_movlw = ir[13:10] == LIT_MOVLW; // RULE9
    wire logic is_retlw = ir[13:10] == LIT_RETLW; // RULE9
    wire logic is_return = ir == INSN_RETURN;
    wire logic is_retfie = ir == INSN_RETFIE;
    // op 0000 with d clear is nop, return or retfie, never a file op
    wire logic is_byte = cls == CLS_BYTE &&
        !(byte_op == OP_MOVWF && !dest_f); // RULE9
    wire logic is_jump = is_call || is_goto;
    wire logic is_pop = is_return || is_retfie || is_retlw;
    wire logic redirect_insn = is_jump || is_pop;
    wire logic reads_f = is_byte && byte_op != OP_MOVWF &&
        byte_op != OP_CLRF;
    wire logic writes_f = is_byte && (byte_op == OP_MOVWF ||
        byte_op == OP_CLRF || dest_f);
    wire logic writes_w = is_byte && !writes_f &&
        (byte_op == OP_MOVF || byte_op == OP_INCF ||
         byte_op == OP_DECF || byte_op == OP_ADDWF);

    // ---- sequencing
    wire logic at_q4 = run && phase == q_write;
    // a redirecting instruction flushes its own prefetch, so an
    // interrupt waits one cycle rather than racing the stack
    wire logic take_irq = at_q4 && gie && irq_s2 && !redirect_insn;
    wire logic push = (at_q4 && is_call) || take_irq; // RULE10 RULE13
    wire logic pop = at_q4 && is_pop;
    wire logic [PC_W-1:0] stack_top = stack[sp - 3'd1];
    wire logic [PC_W-1:0] branch_target =
        {pc_high_latch[5:4], ir[10:0]}; // RULE11

    // ---- data addressing
    wire logic indirect = fld == INDIRECT_LOC;
    wire logic [6:0] eff_low = indirect ? pointer[6:0] : fld; // RULE3 RULE4
    wire logic [1:0] eff_bank = indirect ? {bank[1], pointer[7]} : bank; // RULE12
    wire logic common = eff_low >= COMMON_LO; // RULE2
    wire logic [DADDR_W-1:0] eff_addr =
        {common ? 2'b00 : eff_bank, eff_low}; // RULE2

    // ---- alu, one operation per byte opcode
    wire logic [DATA_W-1:0] alu_out =
        byte_op == OP_MOVWF ? wreg :
        byte_op == OP_CLRF ? 8'h00 :
        byte_op == OP_INCF ? operand + 8'h01 :
        byte_op == OP_DECF ? operand - 8'h01 :
        byte_op == OP_ADDWF ? operand + wreg :
        operand;

    assign dmem_req.addr = eff_addr;
    assign dmem_req.wdata = result; // RULE1
    assign dmem_req.re = run && phase == q_read && reads_f; // RULE7
    assign dmem_req.we = run && phase == q_write && writes_f; // RULE7
    assign prog_addr = pc; // RULE5

    always_comb begin
        case (phase)
            q_decode: next_phase = q_read; // RULE6 RULE7
            q_read: next_phase = q_execute;
            q_execute: next_phase = q_write;
            q_write: next_phase = q_decode;
            default: next_phase = q_decode;
        endcase
    end

    assign next_pc = take_irq ? IRQ_VECTOR : // RULE10
        is_jump ? branch_target : // RULE11
        is_pop ? stack_top :
        pc + 13'd1; // RULE14
    assign next_ir = (take_irq || redirect_insn) ? INSN_NOP : prog_data; // RULE5 RULE8

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= q_decode;
        end else if (run) begin
            phase <= next_phase; // RULE6
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc <= RESET_VECTOR;
            ir <= INSN_NOP;
        end else if (at_q4) begin
            pc <= next_pc; // RULE14
            ir <= next_ir; // RULE5
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            operand <= 8'h00;
            result <= 8'h00;
        end else begin
            if (dmem_req.re) begin
                operand <= dmem_rdata; // RULE1
            end
            if (run && phase == q_execute) begin
                result <= alu_out;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wreg <= 8'h00;
        end else if (at_q4 && writes_w) begin
            wreg <= result;
        end else if (at_q4 && (is_movlw || is_retlw)) begin
            wreg <= ir[7:0];
        end
    end

    // ---- hardware stack: circular, overflow overwrites oldest
    for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                stack[i] <= RESET_VECTOR;
            end else if (push && sp == SP_W'(i)) begin
                stack[i] <= pc; // RULE10 RULE13
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp <= 3'd0;
            depth <= 4'h0;
        end else if (push) begin
            sp <= sp + 3'd1;
            depth <= depth == STACK_FULL ? depth : depth + 4'h1;
        end else if (pop) begin
            sp <= sp - 3'd1;
            depth <= depth == 4'h0 ? depth : depth - 4'h1;
        end
    end

    // ---- interrupt pin synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_s1 <= 1'b0;
            irq_s2 <= 1'b0;
        end else begin
            irq_s1 <= ext_irq;
            irq_s2 <= irq_s1;
        end
    end

    // ---- apb slave, zero wait states, read data latched in setup
    wire logic setup = psel && !penable;
    wire logic wr_acc = psel && penable && pwrite;
    wire logic hit_ctrl = paddr == ADDR_CTRL;
    wire logic hit_pc_high_latch = paddr == ADDR_PC_HIGH_LATCH;
    wire logic hit_pointer = paddr == ADDR_POINTER;
    wire logic hit_bank = paddr == ADDR_BANK;
    wire logic hit_pc = paddr == ADDR_PC;
    wire logic hit_status = paddr == ADDR_STATUS;
    wire logic hit_mask = paddr == ADDR_MASK;
    wire logic hit_wreg = paddr == ADDR_WREG;
    wire logic addr_hit = hit_ctrl || hit_pc_high_latch || hit_pointer ||
        hit_bank || hit_pc || hit_status || hit_mask || hit_wreg;
    wire logic [31:0] rd_mux =
        hit_ctrl ? {30'h0000_0000, gie, run} :
        hit_pc_high_latch ? {24'h00_0000, pc_high_latch} :
        hit_pointer ? {24'h00_0000, pointer} :
        hit_bank ? {30'h0000_0000, bank} :
        hit_pc ? {19'h0_0000, pc} :
        hit_status ? {29'h0000_0000, status} :
        hit_mask ? {29'h0000_0000, mask} :
        hit_wreg ? {24'h00_0000, wreg} :
        32'h0000_0000;

    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_high_latch <= 8'h00;
            pointer <= 8'h00;
            bank <= 2'b00;
            mask <= 3'b000;
            run <= 1'b0;
        end else if (wr_acc) begin
            if (hit_pc_high_latch) pc_high_latch <= pwdata[7:0];
            if (hit_pointer) pointer <= pwdata[7:0];
            if (hit_bank) bank <= pwdata[1:0];
            if (hit_mask) mask <= pwdata[EV_W-1:0];
            if (hit_ctrl) run <= pwdata[CTRL_RUN];
        end
    end

    // interrupt entry masks further entry; return-from-interrupt
    // re-enables; hardware wins over a software write in the same cycle
    wire logic sw_gie_wr = wr_acc && hit_ctrl;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gie <= 1'b0;
        end else if (take_irq) begin
            gie <= 1'b0;
        end else if (at_q4 && is_retfie) begin
            gie <= 1'b1;
        end else if (sw_gie_wr) begin
            gie <= pwdata[CTRL_GIE];
        end
    end

    // ---- sticky events, write one to clear, a new event wins
    wire logic [EV_W-1:0] ev_set;
    assign ev_set[EV_VECTOR] = take_irq;
    assign ev_set[EV_OVERFLOW] = push && depth == STACK_FULL;
    assign ev_set[EV_UNDERFLOW] = pop && depth == 4'h0;
    wire logic [EV_W-1:0] ev_clr =
        (wr_acc && hit_status) ? pwdata[EV_W-1:0] : 3'b000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= 3'b000;
        end else begin
            status <= (status & ~ev_clr) | ev_set;
        end
    end

    assign irq = |(status & mask);

    // ---- assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_cycle_four: assert property ( // RULE6
        (phase == q_decode && run) ##1 run [*3] |=> phase == q_decode)
        else $error("instruction cycle is not four periods");

    a_phase_use: assert property ( // RULE7
        (dmem_req.re |-> phase == q_read) and
        (dmem_req.we |-> phase == q_write))
        else $error("data access outside its phase");

    a_pc_advance: assert property ( // RULE14
        at_q4 && !take_irq && !redirect_insn |=> pc == $past(pc) + 13'd1)
        else $error("program counter did not advance by one");

    a_prefetch_word: assert property ( // RULE5
        at_q4 && !take_irq && !redirect_insn |=> ir == $past(prog_data))
        else $error("prefetched word not taken as next instruction");

    a_irq_vector: assert property ( // RULE10
        take_irq |=> pc == IRQ_VECTOR && stack_top == $past(pc) && !gie)
        else $error("interrupt entry wrong");

    a_call_push: assert property ( // RULE13
        at_q4 && is_call |=> stack_top == $past(pc))
        else $error("call did not save the counter");

    a_call_page: assert property ( // RULE11
        at_q4 && is_jump |=> pc[12:11] == $past(pc_high_latch[5:4]) &&
            pc[10:0] == $past(ir[10:0]))
        else $error("jump target page wrong");

    a_common_ram: assert property ( // RULE2
        (dmem_req.re || dmem_req.we) && dmem_req.addr[6:0] >= COMMON_LO
        |-> dmem_req.addr[8:7] == 2'b00)
        else $error("common ram not shared across banks");

    a_direct_addr: assert property ( // RULE3
        (dmem_req.re || dmem_req.we) && !indirect && fld < COMMON_LO
        |-> dmem_req.addr == {bank, fld})
        else $error("direct address wrong");

    a_indirect_addr: assert property ( // RULE4
        (dmem_req.re || dmem_req.we) && indirect
        |-> dmem_req.addr[6:0] == pointer[6:0])
        else $error("indirect address not from pointer");

    a_read_to_write: assert property ( // RULE8
        dmem_req.re && writes_f |-> ##2 dmem_req.we)
        else $error("read-modify-write not done in one cycle");

    a_event_sticky: assert property ( // RULE10
        |ev_set |=> (status & $past(ev_set)) == $past(ev_set))
        else $error("event did not set its status bit");

    a_fetch_hold: assert property ( // RULE5
        run && !at_q4 |=> $stable(prog_addr))
        else $error("fetch address moved inside a cycle");

endmodule // cfas_core
`default_nettype wire

// ### verification/cfas_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cfas_mem_model
    import cfas_pkg::*;
(
    input wire logic pclk,
    input wire logic [PC_W-1:0] prog_addr,
    output logic [INSTR_W-1:0] prog_data,
    input wire cfas_dmem_req_t dmem_req,
    output logic [DATA_W-1:0] dmem_rdata
);
    logic [INSTR_W-1:0] prog [0:(1<<PC_W)-1];
    logic [DATA_W-1:0] dmem [0:(1<<DADDR_W)-1];
    logic [DATA_W-1:0] last_rd;
    // combinational program array, one 14-bit word per address
    assign prog_data = prog[prog_addr];
    // outside a read the bus shows the inverse of the last value, so a
    // core sampling off its read phase never sees plausible data
    assign dmem_rdata = dmem_req.re ? dmem[dmem_req.addr] : ~last_rd;
    initial begin
        last_rd = 8'h00;
        for (int i = 0; i < (1<<PC_W); i++) prog[i] = INSN_NOP;
        for (int i = 0; i < (1<<DADDR_W); i++) dmem[i] = 8'h00;
    end
    always @(posedge pclk) begin
        if (dmem_req.re) last_rd <= dmem[dmem_req.addr];
        if (dmem_req.we) dmem[dmem_req.addr] <= dmem_req.wdata;
    end
endmodule // cfas_mem_model
`default_nettype wire

// ### verification/tb_core_fetch_addressing_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_core_fetch_addressing_sequencer;
    import cfas_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic ext_irq, irq;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [PC_W-1:0] prog_addr;
    logic [INSTR_W-1:0] prog_data;
    logic [DATA_W-1:0] dmem_rdata;
    cfas_dmem_req_t dmem_req;
    int num_errors = 0;
    int tests_run = 0;
    cfas_core i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .prog_addr(prog_addr), .prog_data(prog_data), .dmem_req(dmem_req),
        .dmem_rdata(dmem_rdata), .ext_irq(ext_irq), .irq(irq));
    cfas_mem_model i_mem (.pclk(pclk), .prog_addr(prog_addr),
        .prog_data(prog_data), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one transfer; request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 50) num_errors++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r, exp);
    endtask

    task automatic wait_pc(input logic [PC_W-1:0] a);
        int n;
        n = 0;
        while (prog_addr !== a && n < 200) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk(prog_addr, a);
    endtask

    task automatic test_regs;
        logic [31:0] r;
        logic e;
        rd(ADDR_CTRL, 32'h0000_0000);
        rd(ADDR_STATUS, 32'h0000_0000);
        rd(ADDR_PC, 32'h0000_0000);
        apb(1'b0, 12'h040, 32'h0000_0000, r, e);
        chk(e, 32'h0000_0001);
        chk(r, 32'h0000_0000);
        wr(ADDR_PC, 32'h0000_0123);
        rd(ADDR_PC, 32'h0000_0000);
        wr(ADDR_PC_HIGH_LATCH, 32'h0000_0010);
        rd(ADDR_PC_HIGH_LATCH, 32'h0000_0010);
        wr(ADDR_POINTER, 32'h0000_0033);
        rd(ADDR_POINTER, 32'h0000_0033);
        wr(ADDR_BANK, 32'h0000_0001);
        rd(ADDR_BANK, 32'h0000_0001);
        wr(ADDR_MASK, 32'h0000_0001);
    endtask

    task automatic test_program;
        int n;
        wr(ADDR_CTRL, 32'h0000_0003);
        wait_pc(13'h0806);
        n = 0;
        while (prog_addr === 13'h0806 && n < 20) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk(n, 32'h0000_0004);
        wait_pc(13'h0810);
        wait_pc(13'h080b);
        chk(i_mem.dmem[9'h0a0], 32'h0000_005b);
        chk(i_mem.dmem[9'h075], 32'h0000_005a);
        chk(i_mem.dmem[9'h0f5], 32'h0000_0000);
        chk(i_mem.dmem[9'h033], 32'h0000_005a);
        rd(ADDR_WREG, 32'h0000_005a);
    endtask

    task automatic test_irq;
        rd(ADDR_STATUS, 32'h0000_0000);
        chk(irq, 32'h0000_0000);
        ext_irq <= 1'b1;
        wait_pc(IRQ_VECTOR);
        wait_pc(13'h080f);
        chk(irq, 32'h0000_0001);
        rd(ADDR_STATUS, 32'h0000_0001);
        rd(ADDR_CTRL, 32'h0000_0001);
        // irq follows the register written at the edge, so look one later
        wr(ADDR_MASK, 32'h0000_0000);
        @(posedge pclk);
        chk(irq, 32'h0000_0000);
        wr(ADDR_MASK, 32'h0000_0001);
        @(posedge pclk);
        chk(irq, 32'h0000_0001);
        ext_irq <= 1'b0;
        wr(ADDR_STATUS, 32'h0000_0001);
        @(posedge pclk);
        chk(irq, 32'h0000_0000);
        rd(ADDR_STATUS, 32'h0000_0000);
    endtask

    // mid-run reset, then a return with an empty stack
    task automatic test_underflow;
        presetn <= 1'b0;
        i_mem.prog[13'h0000] = INSN_RETURN;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_CTRL, 32'h0000_0000);
        rd(ADDR_PC, 32'h0000_0000);
        rd(ADDR_STATUS, 32'h0000_0000);
        wr(ADDR_MASK, 32'h0000_0004);
        wr(ADDR_CTRL, 32'h0000_0001);
        repeat (12) @(posedge pclk);
        rd(ADDR_STATUS, 32'h0000_0004);
        wr(ADDR_CTRL, 32'h0000_0000);
        @(posedge pclk);
        chk(irq, 32'h0000_0001);
        wr(ADDR_STATUS, 32'h0000_0004);
        @(posedge pclk);
        chk(irq, 32'h0000_0000);
    endtask

    task automatic end_of_test;
        $display("errors %0d of %0d checks", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        ext_irq = 1'b0;
        @(posedge pclk);
        // main code sits in page 1; vector 4 stays in page 0
        i_mem.prog[13'h0000] = 14'h2805;
        i_mem.prog[13'h0004] = 14'h280f;
        i_mem.prog[13'h0805] = 14'h305a;
        i_mem.prog[13'h0806] = 14'h00a0;
        i_mem.prog[13'h0807] = 14'h00f5;
        i_mem.prog[13'h0808] = 14'h0080;
        i_mem.prog[13'h0809] = 14'h0aa0;
        i_mem.prog[13'h080a] = 14'h2010;
        i_mem.prog[13'h080b] = 14'h280b;
        i_mem.prog[13'h080f] = 14'h280f;
        i_mem.prog[13'h0810] = INSN_RETURN;
        repeat (11) @(posedge pclk);
        presetn <= 1'b1;
        test_regs();
        test_program();
        test_irq();
        test_underflow();
        end_of_test();
    end

    // whole run needs a few hundred cycles; this leaves wide margin
    initial begin
        #200000;
        num_errors++;
        end_of_test();
    end
endmodule // tb_core_fetch_addressing_sequencer
`default_nettype wire
